// ===== rtl/clock_gen_pkg.sv
// Shared constants, types and helpers of the clock generation unit
package clock_gen_pkg;
    localparam int DIV_W = 3;
    localparam int DIV_CNT_W = 7;
    localparam int TRIM_W = 9;
    localparam int COARSE_W = 8;
    localparam int IRC_CNT_W = 14;
    localparam int CLK_PERIOD_NS = 4;
    // Untrimmed internal reference period
    localparam int IRC_NOM_PERIOD_NS = 32000;
    localparam int IRC_BASE_CYCLES = IRC_NOM_PERIOD_NS / CLK_PERIOD_NS;

    localparam logic [1:0] CLKSEL_FLL = 2'h0;
    localparam logic [1:0] CLKSEL_INT = 2'h1;
    localparam logic [1:0] CLKSEL_EXT = 2'h2;
    localparam logic REFSEL_INT = 1'h1;

    // Fixed-frequency validity in external bypass
    localparam logic [DIV_W-1:0] FF_BUS_DIV_MAX = 3'h3;
    localparam logic [DIV_W-1:0] FF_REF_DIV_MARGIN = 3'h2;

    typedef enum logic [2:0] {
        MODE_FLL_INT = 3'h0,
        MODE_FLL_EXT = 3'h1,
        MODE_BYP_INT = 3'h2,
        MODE_BYP_INT_LP = 3'h3,
        MODE_BYP_EXT = 3'h4,
        MODE_BYP_EXT_LP = 3'h5,
        MODE_STOP = 3'h6
    } mode_t;

    // Low-bit mask for a power-of-two divide code
    function automatic logic [DIV_CNT_W-1:0] pow2Mask(
        input logic [DIV_W-1:0] code);
        return 7'h7F >> (3'h7 - code);
    endfunction
endpackage

// ===== rtl/clock_gen_unit.sv
// Clock generation unit: source selection, modes, dividers, gated clocks
`timescale 1ns/1ps
module clock_gen_unit #(
    parameter int IRC_BASE = clock_gen_pkg::IRC_BASE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Software control fields
    input wire logic [1:0] clkSelect,
    input wire logic refSelect,
    input wire logic [clock_gen_pkg::DIV_W-1:0] refDiv,
    input wire logic [clock_gen_pkg::DIV_W-1:0] busDiv,
    input wire logic lowPowerFllOff,
    input wire logic ircOutEnable,
    input wire logic ircStopEnable,
    input wire logic lockLossIrqEn,
    input wire logic lockLossClear,
    input wire logic trimWrite,
    input wire logic [clock_gen_pkg::TRIM_W-1:0] trimValue,
    input wire logic oscRange,
    // System status
    input wire logic debugModeActive,
    input wire logic stopReq,
    input wire logic [clock_gen_pkg::TRIM_W-1:0] factoryTrim,
    // Analog side
    input wire logic extRefPin,
    input wire logic extOscReady,
    input wire logic dcoTick,
    input wire logic fllLockRaw,
    // Clock outputs
    output logic sysClkTick,
    output logic fixedFreqClk,
    output logic fixedFreqValid,
    output logic ircClk,
    output logic debugLinkClk,
    // Analog control
    output logic fllEnable,
    output logic fllRefTick,
    output logic fllRelock,
    output logic ircRun,
    // Status
    output logic [1:0] clkSelectStatus,
    output logic refSelectStatus,
    output clock_gen_pkg::mode_t mode,
    output logic [clock_gen_pkg::COARSE_W-1:0] coarseTrim,
    output logic fineTrim,
    output logic lockLossFlag,
    output logic lockLossIrq
);
    typedef struct packed {
        clock_gen_pkg::mode_t mode;
        logic [1:0] clk_select_status;
        logic refSt;
        logic extS1;
        logic extS2;
        logic extPrev;
        logic lockS1;
        logic lockS2;
        logic lockPrev;
        logic rdyS1;
        logic rdyS2;
        logic [clock_gen_pkg::TRIM_W-1:0] trim;
        logic trimLoad;
        logic lockLoss;
        logic irq;
        logic sysTick;
        logic ffClk;
        logic ffValid;
        logic ircClk;
        logic dbgClk;
        logic fllEn;
        logic refTick;
        logic relock;
        logic ircRun;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic extTick;
    logic ircTick;
    logic extDivTick;
    logic activeTick;
    logic busTick;

    // Tick of a selectable source
    function automatic logic srcTickOf(input logic [1:0] sel,
        input logic dco, input logic irc, input logic ext);
        case (sel)
            clock_gen_pkg::CLKSEL_FLL: return dco;
            clock_gen_pkg::CLKSEL_INT: return irc;
            clock_gen_pkg::CLKSEL_EXT: return ext;
            default: return 1'b0;
        endcase
    endfunction

    // Whether a source may be switched to
    function automatic logic srcAvail(input logic [1:0] sel,
        input logic locked, input logic extRdy);
        case (sel)
            clock_gen_pkg::CLKSEL_FLL: return locked;
            clock_gen_pkg::CLKSEL_INT: return 1'b1;
            clock_gen_pkg::CLKSEL_EXT: return extRdy;
            default: return 1'b0;
        endcase
    endfunction

    // Mode from active selection; low power needs no pending FLL request
    function automatic clock_gen_pkg::mode_t modeOf(input logic stop,
        input logic [1:0] clk_select_status, input logic refSt, input logic lowPw);
        if (stop)
            return clock_gen_pkg::MODE_STOP;
        case (clk_select_status)
            clock_gen_pkg::CLKSEL_FLL:
                return refSt ? clock_gen_pkg::MODE_FLL_INT
                             : clock_gen_pkg::MODE_FLL_EXT;
            clock_gen_pkg::CLKSEL_INT:
                return lowPw ? clock_gen_pkg::MODE_BYP_INT_LP
                             : clock_gen_pkg::MODE_BYP_INT;
            default:
                return lowPw ? clock_gen_pkg::MODE_BYP_EXT_LP
                             : clock_gen_pkg::MODE_BYP_EXT;
        endcase
    endfunction

    // FLL modes always meet the quarter-rate limit; internal bypass never
    function automatic logic ffValidOf(input clock_gen_pkg::mode_t m,
        input logic [2:0] bus_div, input logic [2:0] ref_div, input logic rng);
        case (m)
            clock_gen_pkg::MODE_FLL_INT,
            clock_gen_pkg::MODE_FLL_EXT: return 1'b1;
            clock_gen_pkg::MODE_BYP_EXT,
            clock_gen_pkg::MODE_BYP_EXT_LP:
                return rng && (bus_div <= clock_gen_pkg::FF_BUS_DIV_MAX) &&
                    (ref_div >= bus_div + clock_gen_pkg::FF_REF_DIV_MARGIN);
            default: return 1'b0;
        endcase
    endfunction

    assign extTick = st_r.extS2 & ~st_r.extPrev;
    // Internal ticks feed the output only in internal bypass modes
    assign activeTick = srcTickOf(st_r.clk_select_status, dcoTick, ircTick, extTick);

    irc_osc #(
        .BASE(IRC_BASE)
    ) u_irc (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .run(st_r.ircRun),
        .trim(st_r.trim),
        .tick(ircTick)
    );

    // Lock range of the divided reference is up to software
    pow2_tick_div u_refDiv (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tickIn(extTick),
        .divCode(refDiv),
        .tickOut(extDivTick)
    );

    pow2_tick_div u_busDiv (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tickIn(activeTick),
        .divCode(busDiv),
        .tickOut(busTick)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.extS1 = extRefPin;
        st_nxt.extS2 = st_r.extS1;
        st_nxt.extPrev = st_r.extS2;
        st_nxt.lockS1 = fllLockRaw;
        st_nxt.lockS2 = st_r.lockS1;
        st_nxt.lockPrev = st_r.lockS2;
        st_nxt.rdyS1 = extOscReady;
        st_nxt.rdyS2 = st_r.rdyS1;
        st_nxt.relock = 1'b0;

        // Reference switch completes on a tick of the new reference
        if (refSelect != st_r.refSt)
        begin
            if (refSelect ? ircTick : (extDivTick && st_r.rdyS2))
            begin
                st_nxt.refSt = refSelect;
                st_nxt.relock = (st_r.clk_select_status ==
                    clock_gen_pkg::CLKSEL_FLL);
            end
        end

        // Source switch waits for availability and an edge of it
        if (clkSelect != st_r.clk_select_status &&
            srcAvail(clkSelect, st_r.lockS2, st_r.rdyS2) &&
            srcTickOf(clkSelect, dcoTick, ircTick, extTick))
        begin
            st_nxt.clk_select_status = clkSelect;
        end

        st_nxt.mode = modeOf(stopReq, st_nxt.clk_select_status,
            st_nxt.refSt, lowPowerFllOff && !debugModeActive &&
            clkSelect != clock_gen_pkg::CLKSEL_FLL);

        // FLL runs unless low-power bypass or stop
        st_nxt.fllEn = !(st_nxt.mode == clock_gen_pkg::MODE_BYP_INT_LP ||
            st_nxt.mode == clock_gen_pkg::MODE_BYP_EXT_LP ||
            st_nxt.mode == clock_gen_pkg::MODE_STOP);

        // Always on outside stop, so switching to it costs no start-up
        st_nxt.ircRun = (st_nxt.mode != clock_gen_pkg::MODE_STOP) ||
            (ircOutEnable && ircStopEnable);

        // DCO locks at 512x this reference
        st_nxt.refTick = st_r.refSt ? ircTick : extDivTick;

        st_nxt.sysTick = busTick &&
            st_r.mode != clock_gen_pkg::MODE_STOP;
        if (st_r.refTick && st_r.mode != clock_gen_pkg::MODE_STOP)
            st_nxt.ffClk = ~st_r.ffClk;
        st_nxt.ffValid = ffValidOf(st_nxt.mode, busDiv, refDiv, oscRange);

        if (ircTick && ircOutEnable &&
            (st_r.mode != clock_gen_pkg::MODE_STOP || ircStopEnable))
            st_nxt.ircClk = ~st_r.ircClk;

        // Halved DCO only where the FLL is on and not stopped
        if (dcoTick && (st_r.mode == clock_gen_pkg::MODE_FLL_INT ||
            st_r.mode == clock_gen_pkg::MODE_FLL_EXT ||
            st_r.mode == clock_gen_pkg::MODE_BYP_INT ||
            st_r.mode == clock_gen_pkg::MODE_BYP_EXT))
            st_nxt.dbgClk = ~st_r.dbgClk;

        // Set wins over a simultaneous clear
        st_nxt.lockLoss = (st_r.lockPrev && !st_r.lockS2 && st_r.fllEn &&
            st_r.mode != clock_gen_pkg::MODE_STOP) ||
            (st_r.lockLoss && !lockLossClear);
        st_nxt.irq = st_nxt.lockLoss && lockLossIrqEn;

        // First cycle after reset takes the factory trim
        if (st_r.trimLoad)
        begin
            st_nxt.trim = factoryTrim;
            st_nxt.trimLoad = 1'b0;
        end
        else if (trimWrite)
        begin
            st_nxt.trim = trimValue;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.mode <= clock_gen_pkg::MODE_FLL_INT;
            st_r.refSt <= clock_gen_pkg::REFSEL_INT;
            st_r.trimLoad <= 1'b1;
            st_r.ircRun <= 1'b1;
            st_r.fllEn <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sysClkTick = st_r.sysTick;
    assign fixedFreqClk = st_r.ffClk;
    assign fixedFreqValid = st_r.ffValid;
    assign ircClk = st_r.ircClk;
    assign debugLinkClk = st_r.dbgClk;
    assign fllEnable = st_r.fllEn;
    assign fllRefTick = st_r.refTick;
    assign fllRelock = st_r.relock;
    assign ircRun = st_r.ircRun;
    assign clkSelectStatus = st_r.clk_select_status;
    assign refSelectStatus = st_r.refSt;
    assign mode = st_r.mode;
    assign coarseTrim = st_r.trim[clock_gen_pkg::TRIM_W-1:1];
    assign fineTrim = st_r.trim[0];
    assign lockLossFlag = st_r.lockLoss;
    assign lockLossIrq = st_r.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    resetMode_a: assert property ($rose(rstn) |->
        mode == clock_gen_pkg::MODE_FLL_INT)
        else $error("reset did not give FLL internal mode");

    trimLoad_a: assert property ($rose(rstn) |=>
        {coarseTrim, fineTrim} == $past(factoryTrim))
        else $error("factory trim not loaded after reset");

    ircGate_a: assert property ($changed(ircClk) |->
        $past(ircOutEnable))
        else $error("irc clock moved while output disabled");

    lowPowerOff_a: assert property (
        (mode == clock_gen_pkg::MODE_BYP_INT_LP ||
        mode == clock_gen_pkg::MODE_BYP_EXT_LP ||
        mode == clock_gen_pkg::MODE_STOP) |-> !fllEnable)
        else $error("FLL enabled in low-power bypass or stop");

    stopStatic_a: assert property (
        mode == clock_gen_pkg::MODE_STOP |=> $stable(debugLinkClk) &&
        $stable(fixedFreqClk) && !sysClkTick)
        else $error("clock output active in stop");

    ircStopRun_a: assert property (
        stopReq && ircOutEnable && ircStopEnable |=> ircRun)
        else $error("internal reference stopped in stop mode");

    debugLink_a: assert property ($changed(debugLinkClk) |->
        $past(mode) != clock_gen_pkg::MODE_BYP_INT_LP &&
        $past(mode) != clock_gen_pkg::MODE_BYP_EXT_LP)
        else $error("debug link clock in low-power bypass");

    ffValid_a: assert property (fixedFreqValid &&
        mode == clock_gen_pkg::MODE_BYP_EXT |->
        $past(oscRange) && $past(busDiv) <= clock_gen_pkg::FF_BUS_DIV_MAX)
        else $error("fixed clock valid outside allowed pairs");

    lockSticky_a: assert property (
        lockLossFlag && !lockLossClear |=> lockLossFlag)
        else $error("lock loss flag lost without clear");

    unavailSrc_a: assert property (
        clkSelect == 2'h3 |=> $stable(clkSelectStatus))
        else $error("switched to an unavailable source");

    relock_a: assert property (fllRelock |->
        $changed(refSelectStatus) &&
        clkSelectStatus == clock_gen_pkg::CLKSEL_FLL)
        else $error("relock without reference switch");

    extMode_c: cover property (mode == clock_gen_pkg::MODE_FLL_EXT);
    lpMode_c: cover property (mode == clock_gen_pkg::MODE_BYP_INT_LP);
    stopMode_c: cover property (mode == clock_gen_pkg::MODE_STOP);
    lockLoss_c: cover property ($rose(lockLossFlag));
endmodule // clock_gen_unit

// ===== rtl/irc_osc.sv
// Trimmable internal reference oscillator model
`timescale 1ns/1ps
module irc_osc #(
    parameter int BASE = clock_gen_pkg::IRC_BASE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Control
    input wire logic run,
    input wire logic [clock_gen_pkg::TRIM_W-1:0] trim,
    // Reference tick
    output logic tick
);
    localparam int CW = clock_gen_pkg::IRC_CNT_W;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } irc_state_t;

    irc_state_t st_r;
    irc_state_t st_nxt;
    logic [CW-1:0] period;

    // Larger trim gives a longer period
    assign period = CW'(BASE) + CW'(trim);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= period - CW'(1))
        begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;
endmodule // irc_osc

// ===== rtl/pow2_tick_div.sv
// Power-of-two divider on a tick stream
`timescale 1ns/1ps
module pow2_tick_div #(
    parameter int W = clock_gen_pkg::DIV_W,
    parameter int CW = clock_gen_pkg::DIV_CNT_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Ticks in and divide code
    input wire logic tickIn,
    input wire logic [W-1:0] divCode,
    // Divided tick
    output logic tickOut
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tickOut;
    } div_state_t;

    div_state_t st_r;
    div_state_t st_nxt;
    logic [CW-1:0] mask;

    // Mask taken live, so a new code acts at once
    assign mask = clock_gen_pkg::pow2Mask(divCode);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tickOut = 1'b0;
        if (tickIn)
        begin
            st_nxt.cnt = st_r.cnt + CW'(1);
            st_nxt.tickOut = ((st_r.cnt & mask) == mask);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tickOut = st_r.tickOut;
endmodule // pow2_tick_div

// ===== test/analog_model.sv
// Behavioural model of the analog side: DCO, external reference and lock
`timescale 1ns/1ps
module analog_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // From the unit and the bench
    input wire logic fllEnable,
    input wire logic dropLock,
    // Analog outputs
    output logic dcoTick,
    output logic extRefPin,
    output logic extOscReady,
    output logic fllLockRaw
);
    logic [4:0] cnt;
    logic [3:0] lockCnt;
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cnt <= 5'h00;
            lockCnt <= 4'h0;
            extOscReady <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 5'h01;
            // Oscillator needs a start-up span before it is usable
            if (cnt == 5'h1F)
                extOscReady <= 1'b1;
            // Lock is acquired afresh each time the loop is powered
            if (!fllEnable || dropLock)
                lockCnt <= 4'h0;
            else if (lockCnt != 4'hF)
                lockCnt <= lockCnt + 4'h1;
        end
    end
    // A powered-down loop gives no DCO ticks at all
    assign dcoTick = fllEnable & cnt[0];
    assign extRefPin = cnt[1];
    assign fllLockRaw = lockCnt >= 4'h8;
endmodule // analog_model

// ===== test/clock_gen_unit_tb.sv
// Self-checking bench of the clock generation unit
`timescale 1ns/1ps
module clock_gen_unit_tb;
    localparam int BASE = 16;
    logic clk_sys = 1'b0, rstn = 1'b0;
    logic [1:0] clkSelect, clkSelectStatus;
    logic [2:0] refDiv, busDiv;
    logic refSelect, lowPowerFllOff, ircOutEnable, ircStopEnable;
    logic lockLossIrqEn, lockLossClear, trimWrite, oscRange, dropLock;
    logic debugModeActive, stopReq, extRefPin, extOscReady, dcoTick;
    logic fllLockRaw, sysClkTick, fixedFreqClk, fixedFreqValid, ircClk;
    logic debugLinkClk, fllEnable, fllRefTick, fllRelock, ircRun;
    logic refSelectStatus, fineTrim, lockLossFlag, lockLossIrq;
    logic [8:0] trimValue, factoryTrim;
    logic [7:0] coarseTrim;
    clock_gen_pkg::mode_t mode;
    logic ircQ, dbgQ, ffQ;
    int nErrors = 0, nTests = 0;
    int nDco = 0, nSys = 0, nIrc = 0, nDbg = 0, nRel = 0;
    int dD, dS, dI, dG, dR;
    int nFf = 0, nRef = 0, dF, dT;

    always #2 clk_sys = ~clk_sys;

    clock_gen_unit #(.IRC_BASE(BASE)) uut (.clk_sys(clk_sys), .rstn(rstn),
        .clkSelect(clkSelect), .refSelect(refSelect), .refDiv(refDiv),
        .busDiv(busDiv), .lowPowerFllOff(lowPowerFllOff),
        .ircOutEnable(ircOutEnable), .ircStopEnable(ircStopEnable),
        .lockLossIrqEn(lockLossIrqEn), .lockLossClear(lockLossClear),
        .trimWrite(trimWrite), .trimValue(trimValue), .oscRange(oscRange),
        .debugModeActive(debugModeActive), .stopReq(stopReq),
        .factoryTrim(factoryTrim), .extRefPin(extRefPin),
        .extOscReady(extOscReady), .dcoTick(dcoTick),
        .fllLockRaw(fllLockRaw), .sysClkTick(sysClkTick),
        .fixedFreqClk(fixedFreqClk), .fixedFreqValid(fixedFreqValid),
        .ircClk(ircClk), .debugLinkClk(debugLinkClk),
        .fllEnable(fllEnable), .fllRefTick(fllRefTick),
        .fllRelock(fllRelock), .ircRun(ircRun),
        .clkSelectStatus(clkSelectStatus),
        .refSelectStatus(refSelectStatus), .mode(mode),
        .coarseTrim(coarseTrim), .fineTrim(fineTrim),
        .lockLossFlag(lockLossFlag), .lockLossIrq(lockLossIrq));

    analog_model far (.clk_sys(clk_sys), .rstn(rstn),
        .fllEnable(fllEnable), .dropLock(dropLock), .dcoTick(dcoTick),
        .extRefPin(extRefPin), .extOscReady(extOscReady),
        .fllLockRaw(fllLockRaw));

    // Edge counters, so clock rates are judged over a window
    always @(posedge clk_sys)
    begin
        ircQ <= ircClk;
        dbgQ <= debugLinkClk;
        ffQ <= fixedFreqClk;
        nFf <= nFf + int'(fixedFreqClk ^ ffQ);
        nRef <= nRef + int'(fllRefTick);
        nDco <= nDco + int'(dcoTick);
        nSys <= nSys + int'(sysClkTick);
        nIrc <= nIrc + int'(ircClk ^ ircQ);
        nDbg <= nDbg + int'(debugLinkClk ^ dbgQ);
        nRel <= nRel + int'(fllRelock);
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        nTests++;
        if (got !== exp)
        begin
            nErrors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Window counts may be off by one from the free-running phase
    task automatic near(input int got, input int exp);
        nTests++;
        if (got < exp - 1 || got > exp + 1)
        begin
            nErrors++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic chkMode(input clock_gen_pkg::mode_t m);
        chk({6'h00, mode}, {6'h00, m});
    endtask

    task automatic meas(input int w);
        int a, b, c, d, e, f, g;
        a = nDco;
        f = nFf;
        g = nRef;
        b = nSys;
        c = nIrc;
        d = nDbg;
        e = nRel;
        repeat (w) @(posedge clk_sys);
        dD = nDco - a;
        dS = nSys - b;
        dI = nIrc - c;
        dG = nDbg - d;
        dR = nRel - e;
        dF = nFf - f;
        dT = nRef - g;
    endtask

    task automatic waitSt(input logic [1:0] s, input logic r);
        for (int i = 0; i < 300; i++)
        begin
            @(negedge clk_sys);
            if (clkSelectStatus === s && refSelectStatus === r)
                break;
        end
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic t_reset;
        repeat (2) @(negedge clk_sys);
        chkMode(clock_gen_pkg::MODE_FLL_INT);
        chk({7'h00, clkSelectStatus}, 9'h000);
        chk({8'h00, refSelectStatus}, 9'h001);
        chk({coarseTrim, fineTrim}, factoryTrim);
        chk({8'h00, fixedFreqValid}, 9'h001);
    endtask

    task automatic t_busdiv;
        for (int d = 0; d < 8; d++)
        begin
            @(posedge clk_sys) busDiv <= 3'(d);
            // No switch point: the window opens three cycles after the write
            repeat (3) @(posedge clk_sys);
            meas(1024);
            near(dS, dD >> d);
            near(dG, dD);
        end
        @(posedge clk_sys) busDiv <= 3'h0;
    endtask

    task automatic t_irc;
        @(posedge clk_sys) ircOutEnable <= 1'b0;
        // A toggle launched on the disabling edge is still legal
        repeat (2) @(posedge clk_sys);
        meas(100);
        chk(9'(dI), 9'h000);
        @(posedge clk_sys) ircOutEnable <= 1'b1;
        trimWrite <= 1'b1;
        trimValue <= 9'h00B;
        @(posedge clk_sys) trimWrite <= 1'b0;
        @(negedge clk_sys);
        chk({coarseTrim, fineTrim}, 9'h00B);
        meas(540);
        near(dI, 540 / (BASE + 11));
        near(dF, 540 / (BASE + 11));
        near(dT, 540 / (BASE + 11));
        @(posedge clk_sys) trimWrite <= 1'b1;
        trimValue <= 9'h003;
        @(posedge clk_sys) trimWrite <= 1'b0;
        meas(380);
        near(dI, 380 / (BASE + 3));
    endtask

    task automatic t_lockloss;
        @(posedge clk_sys) lockLossIrqEn <= 1'b1;
        dropLock <= 1'b1;
        repeat (8) @(negedge clk_sys);
        chk({7'h00, lockLossFlag, lockLossIrq}, 9'h003);
        @(posedge clk_sys) dropLock <= 1'b0;
        repeat (20) @(negedge clk_sys);
        chk({8'h00, lockLossFlag}, 9'h001);
        @(posedge clk_sys) lockLossClear <= 1'b1;
        @(posedge clk_sys) lockLossClear <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({7'h00, lockLossFlag, lockLossIrq}, 9'h000);
    endtask

    task automatic t_bypint;
        @(posedge clk_sys) clkSelect <= clock_gen_pkg::CLKSEL_INT;
        waitSt(2'h1, 1'b1);
        chkMode(clock_gen_pkg::MODE_BYP_INT);
        chk({8'h00, fixedFreqValid}, 9'h000);
        meas(380);
        near(dS, 380 / (BASE + 3));
        near(dG, dD);
        @(posedge clk_sys) lowPowerFllOff <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chkMode(clock_gen_pkg::MODE_BYP_INT_LP);
        chk({8'h00, fllEnable}, 9'h000);
        meas(100);
        chk(9'(dG), 9'h000);
        @(posedge clk_sys) debugModeActive <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chkMode(clock_gen_pkg::MODE_BYP_INT);
        @(posedge clk_sys) debugModeActive <= 1'b0;
        clkSelect <= 2'h3;
        meas(60);
        chk({7'h00, clkSelectStatus}, 9'h001);
    endtask

    task automatic t_bypext;
        @(posedge clk_sys) refSelect <= 1'b0;
        lowPowerFllOff <= 1'b0;
        clkSelect <= clock_gen_pkg::CLKSEL_EXT;
        waitSt(2'h2, 1'b0);
        chkMode(clock_gen_pkg::MODE_BYP_EXT);
        for (int b = 0; b < 8; b++)
            for (int r = 0; r < 8; r++)
            begin
                @(posedge clk_sys) busDiv <= 3'(b);
                refDiv <= 3'(r);
                repeat (3) @(negedge clk_sys);
                chk(9'(b <= 3 && r >= b + 2),
                    {8'h00, fixedFreqValid});
            end
        @(posedge clk_sys) oscRange <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({8'h00, fixedFreqValid}, 9'h000);
        @(posedge clk_sys) lowPowerFllOff <= 1'b1;
        busDiv <= 3'h0;
        repeat (3) @(negedge clk_sys);
        chkMode(clock_gen_pkg::MODE_BYP_EXT_LP);
    endtask

    task automatic t_fllext;
        @(posedge clk_sys) lowPowerFllOff <= 1'b0;
        refDiv <= 3'h2;
        clkSelect <= clock_gen_pkg::CLKSEL_FLL;
        waitSt(2'h0, 1'b0);
        chkMode(clock_gen_pkg::MODE_FLL_EXT);
        chk({8'h00, fixedFreqValid}, 9'h001);
        meas(200);
        near(dG, dD);
        // Model reference ticks every 4 cycles, then divided by 4
        near(dT, 200 / (4 * 4));
        @(posedge clk_sys) refSelect <= 1'b1;
        fork
            meas(300);
            waitSt(2'h0, 1'b1);
        join
        chk(9'(dR > 0), 9'h001);
        chkMode(clock_gen_pkg::MODE_FLL_INT);
    endtask

    task automatic t_stop;
        @(posedge clk_sys) stopReq <= 1'b1;
        ircStopEnable <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chkMode(clock_gen_pkg::MODE_STOP);
        chk({8'h00, fllEnable}, 9'h000);
        chk({8'h00, ircRun}, 9'h000);
        meas(100);
        chk({7'h00, 1'(dS > 0), 1'(dI > 0)}, 9'h000);
        chk(9'(dF), 9'h000);
        @(posedge clk_sys) ircStopEnable <= 1'b1;
        meas(380);
        near(dI, 380 / (BASE + 3));
        chk(9'(dS), 9'h000);
        chk({8'h00, ircRun}, 9'h001);
        @(posedge clk_sys) stopReq <= 1'b0;
        repeat (4) @(negedge clk_sys);
        chkMode(clock_gen_pkg::MODE_FLL_INT);
    endtask

    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        // Arbitrary factory trim, kept small for short reference periods
        {clkSelect, refSelect, refDiv, busDiv} = {2'h0, 1'b1, 6'h00};
        {lowPowerFllOff, ircOutEnable, ircStopEnable} = 3'h2;
        {lockLossIrqEn, lockLossClear, trimWrite, dropLock} = 4'h0;
        {oscRange, debugModeActive, stopReq} = 3'h4;
        trimValue = 9'h000;
        factoryTrim = 9'h004;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        repeat (20) @(posedge clk_sys);
        t_busdiv();
        t_irc();
        t_lockloss();
        t_bypint();
        t_bypext();
        t_fllext();
        t_stop();
        reportAndStop();
    end

    // Whole run is about 11000 cycles; this leaves ample margin
    initial
    begin
        #150000;
        nErrors++;
        reportAndStop();
    end
endmodule // clock_gen_unit_tb
